// *** limit_alert_defines.svh ***
// Purpose: Offsets, field positions, reset values for the limit alert block
// Assumes: 16-bit register words, 4-bit register address field
// Notes: Included by its bare name
`ifndef LIMIT_ALERT_DEFINES_SVH
`define LIMIT_ALERT_DEFINES_SVH

`define REG_CONFIG2 4'h2
`define REG_STATUS 4'h3
`define REG_LOW_THR 4'h4
`define REG_HIGH_THR 4'h5
`define REG_IRQ_CLEAR 4'h6
`define REG_IRQ_ENABLE 4'h7

`define ADDR_MSB 15
`define ADDR_LSB 12
`define LIMIT_MSB 11
`define LIMIT_LSB 0

`define BIT_A_LOW 0
`define BIT_A_HIGH 1
`define BIT_B_LOW 4
`define BIT_B_HIGH 5

`define LOW_THR_RESET 12'h800
`define HIGH_THR_RESET 12'h7ff
`define LOW_FILL 4'h0
`define HIGH_FILL 4'hf
`define SOFT_RESET_CODE 8'h3c
`define HARD_RESET_CODE 8'hff

`endif

// *** limit_alert_pkg.sv ***
// Purpose: Types shared by the limit alert files
// Assumes: Two channels of 16-bit results
// Notes: Types only
`default_nettype none
package limit_alert_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] chan_a;
    logic [15:0] chan_b;
  } conv_result_t;

  typedef struct packed {
    logic lower;
    logic upper;
  } limit_hit_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SOFT,
    ST_HARD
  } rst_state_t;
endpackage
`default_nettype wire

// *** limit_compare.sv ***
// Purpose: Compares one result against the widened thresholds
// Assumes: Unsigned 16-bit results
// Notes: Pure combinational
`timescale 1ns/1ps
`default_nettype none
`include "limit_alert_defines.svh"
module limit_compare
  import limit_alert_pkg::*;
#(
  parameter int LIMIT_W = 12,
  parameter int DATA_W = 16
) (
  // Thresholds
  input wire logic [LIMIT_W-1:0] low_limit,
  input wire logic [LIMIT_W-1:0] high_limit,
  // Result
  input wire logic [DATA_W-1:0] result,
  output var limit_hit_t hit
);
  logic [DATA_W-1:0] low_wide;
  logic [DATA_W-1:0] high_wide;
  logic lower_hit;
  logic upper_hit;

  // Widen thresholds
  assign low_wide = DATA_W'({low_limit, `LOW_FILL}); // RULE5
  assign high_wide = DATA_W'({high_limit, `HIGH_FILL}); // RULE7
  assign lower_hit = (result < low_wide); // RULE6
  assign upper_hit = (result > high_wide); // RULE8
  assign hit = {lower_hit, upper_hit};
endmodule // limit_compare
`default_nettype wire

// *** limit_alert.sv ***
// Purpose: Dual-channel limit alert with sticky flags and interrupt
// Assumes: Results arrive with a one-cycle valid at end of conversion
// Notes: Register words carry their own address in the top nibble
//
// Function
// RULE1 - A channel B result above the high threshold sets the B upper flag, held until status is read.
// RULE2 - A channel B result below the low threshold sets the B lower flag, held until status is read.
// RULE3 - A channel A result above the high threshold sets the A upper flag, held until status is read.
// RULE4 - A channel A result below the low threshold sets the A lower flag, held until status is read.
// RULE5 - The internal low threshold is the 12-bit low value over four zero bits.
// RULE6 - A result below the internal low threshold raises a low indication, else not.
// RULE7 - The internal high threshold is the 12-bit high value over four one bits.
// RULE8 - A result above the internal high threshold raises a high indication, else not.
// RULE9 - The low threshold register reads 0x0800 after reset.
// RULE10 - The high threshold register reads 0x07ff after reset.
// RULE11 - Every register word returns its own address in bits 15 to 12; status reads zero there, config and thresholds echo the written bits.
// RULE12 - Writing the soft reset code clears all limit flags and keeps other registers.
// RULE13 - The status register is at address 3 and reads zero after reset.
// RULE14 - Both thresholds are checked for each channel on every conversion, reserved bits read zero.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "limit_alert_defines.svh"
module limit_alert
  import limit_alert_pkg::*;
#(
  parameter int LIMIT_W = 12,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire reg_req_t req,
  output logic [15:0] rdata,
  // Conversion results
  input wire conv_result_t conv,
  // Flags and interrupt
  output logic [5:0] flags,
  output logic irq
);
  // ************************************************************
  // Declarations
  // ************************************************************
  logic [LIMIT_W-1:0] low_thr_r;
  logic [LIMIT_W-1:0] high_thr_r;
  logic [7:0] cfg_reset_r;
  logic [3:0] low_addr_r;
  logic [3:0] high_addr_r;
  logic [3:0] cfg_addr_r;
  logic chan_a_lower_flag_r;
  logic chan_a_upper_flag_r;
  logic chan_b_lower_flag_r;
  logic chan_b_upper_flag_r;
  logic [5:0] irq_stat_r;
  logic [5:0] irq_en_r;
  logic [15:0] rdata_r;
  logic [15:0] status_word;
  logic [5:0] event_vec;
  logic status_read;
  logic soft_rst;
  logic hard_rst;
  logic wr_low;
  logic wr_high;
  rst_state_t rst_state_r;
  limit_hit_t hit_a;
  limit_hit_t hit_b;

  // ************************************************************
  // Comparators
  // ************************************************************
  limit_compare #(.LIMIT_W(LIMIT_W), .DATA_W(DATA_W)) u_cmp_a (
    .low_limit(low_thr_r),
    .high_limit(high_thr_r),
    .result(conv.chan_a),
    .hit(hit_a)
  );

  limit_compare #(.LIMIT_W(LIMIT_W), .DATA_W(DATA_W)) u_cmp_b (
    .low_limit(low_thr_r),
    .high_limit(high_thr_r),
    .result(conv.chan_b),
    .hit(hit_b)
  );

  // ************************************************************
  // Decode
  // ************************************************************
  assign status_read = req.rd && (req.addr == `REG_STATUS); // RULE13
  assign wr_low = req.wr && (req.addr == `REG_LOW_THR);
  assign wr_high = req.wr && (req.addr == `REG_HIGH_THR);
  assign soft_rst = req.wr && (req.addr == `REG_CONFIG2) &&
    (req.wdata[7:0] == `SOFT_RESET_CODE); // RULE12
  assign hard_rst = req.wr && (req.addr == `REG_CONFIG2) &&
    (req.wdata[7:0] == `HARD_RESET_CODE);

  // ************************************************************
  // Reset command tracking
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      rst_state_r <= ST_RUN;
    end else begin
      case (rst_state_r)
        ST_RUN: begin
          if (hard_rst) begin
            rst_state_r <= ST_HARD;
          end else if (soft_rst) begin
            rst_state_r <= ST_SOFT;
          end
        end
        ST_SOFT: rst_state_r <= ST_RUN;
        ST_HARD: rst_state_r <= ST_RUN;
        default: rst_state_r <= ST_RUN;
      endcase
    end
  end

  // Configuration reset field
  always_ff @(posedge clock) begin
    if (rst || hard_rst) begin
      cfg_reset_r <= 8'h00;
    end else if (req.wr && req.addr == `REG_CONFIG2) begin
      cfg_reset_r <= req.wdata[7:0];
    end
  end

  // ************************************************************
  // Threshold registers
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst || hard_rst) begin
      low_thr_r <= LIMIT_W'(`LOW_THR_RESET); // RULE9
    end else if (wr_low) begin
      low_thr_r <= req.wdata[LIMIT_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst || hard_rst) begin
      high_thr_r <= LIMIT_W'(`HIGH_THR_RESET); // RULE10
    end else if (wr_high) begin
      high_thr_r <= req.wdata[LIMIT_W-1:0];
    end
  end

  // ************************************************************
  // Address fields, zero until a write loads them
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst || hard_rst) begin
      low_addr_r <= 4'h0; // RULE9
      high_addr_r <= 4'h0; // RULE10
      cfg_addr_r <= 4'h0;
    end else begin
      if (wr_low) begin
        low_addr_r <= req.wdata[`ADDR_MSB:`ADDR_LSB]; // RULE11
      end
      if (wr_high) begin
        high_addr_r <= req.wdata[`ADDR_MSB:`ADDR_LSB]; // RULE11
      end
      if (req.wr && req.addr == `REG_CONFIG2) begin
        cfg_addr_r <= req.wdata[`ADDR_MSB:`ADDR_LSB]; // RULE11
      end
    end
  end

  // ************************************************************
  // Sticky limit flags, set wins over read clear
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst || hard_rst || soft_rst) begin // RULE12
      chan_a_lower_flag_r <= 1'b0;
      chan_a_upper_flag_r <= 1'b0;
      chan_b_lower_flag_r <= 1'b0;
      chan_b_upper_flag_r <= 1'b0;
    end else begin
      if (conv.valid && hit_a.lower) begin // RULE14
        chan_a_lower_flag_r <= 1'b1; // RULE4
      end else if (status_read) begin
        chan_a_lower_flag_r <= 1'b0;
      end
      if (conv.valid && hit_a.upper) begin
        chan_a_upper_flag_r <= 1'b1; // RULE3
      end else if (status_read) begin
        chan_a_upper_flag_r <= 1'b0;
      end
      if (conv.valid && hit_b.lower) begin
        chan_b_lower_flag_r <= 1'b1; // RULE2
      end else if (status_read) begin
        chan_b_lower_flag_r <= 1'b0;
      end
      if (conv.valid && hit_b.upper) begin
        chan_b_upper_flag_r <= 1'b1; // RULE1
      end else if (status_read) begin
        chan_b_upper_flag_r <= 1'b0;
      end
    end
  end

  // Read-only address field and reserved bits read zero
  assign status_word = {4'h0, 6'h00, chan_b_upper_flag_r,
    chan_b_lower_flag_r, 2'h0, chan_a_upper_flag_r,
    chan_a_lower_flag_r}; // RULE14
  assign flags = status_word[5:0];

  // ************************************************************
  // Interrupt
  // ************************************************************
  assign event_vec = {conv.valid & hit_b.upper, conv.valid & hit_b.lower,
    2'b00, conv.valid & hit_a.upper, conv.valid & hit_a.lower};

  always_ff @(posedge clock) begin
    if (rst || hard_rst) begin
      irq_stat_r <= 6'h00;
    end else if (req.wr && req.addr == `REG_IRQ_CLEAR) begin
      irq_stat_r <= (irq_stat_r & ~req.wdata[5:0]) | event_vec;
    end else begin
      irq_stat_r <= irq_stat_r | event_vec;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || hard_rst) begin
      irq_en_r <= 6'h00;
    end else if (req.wr && req.addr == `REG_IRQ_ENABLE) begin
      irq_en_r <= req.wdata[5:0] & 6'h33;
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // ************************************************************
  // Read data
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        `REG_CONFIG2: rdata_r <= {cfg_addr_r, 4'h0, cfg_reset_r}; // RULE11
        `REG_STATUS: rdata_r <= status_word; // RULE13
        `REG_LOW_THR: rdata_r <= 16'({low_addr_r, low_thr_r}); // RULE11
        `REG_HIGH_THR: rdata_r <= 16'({high_addr_r, high_thr_r}); // RULE11
        `REG_IRQ_ENABLE: rdata_r <= {`REG_IRQ_ENABLE, 6'h00, irq_en_r};
        `REG_IRQ_CLEAR: rdata_r <= {`REG_IRQ_CLEAR, 6'h00, irq_stat_r};
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end
  assign rdata = rdata_r;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence hit_b_up_s;
    conv.valid && hit_b.upper;
  endsequence
  sequence hit_a_low_s;
    conv.valid && hit_a.lower;
  endsequence
  sequence no_clear_s;
    !soft_rst && !hard_rst;
  endsequence

  b_upper_set_a: assert property (@(posedge clock) disable iff (rst) // RULE1
    hit_b_up_s ##0 no_clear_s |=> chan_b_upper_flag_r)
    else $error("B upper flag not set");
  b_lower_set_a: assert property (@(posedge clock) disable iff (rst) // RULE2
    conv.valid && conv.chan_b < {low_thr_r, 4'h0} && !hard_rst && !soft_rst
    |=> chan_b_lower_flag_r)
    else $error("B lower flag not set");
  a_upper_set_a: assert property (@(posedge clock) disable iff (rst) // RULE3
    conv.valid && conv.chan_a > {high_thr_r, 4'hf} && !hard_rst && !soft_rst
    |=> chan_a_upper_flag_r)
    else $error("A upper flag not set");
  a_lower_hold_a: assert property (@(posedge clock) disable iff (rst) // RULE4
    hit_a_low_s ##0 no_clear_s ##1 (!status_read && !soft_rst && !hard_rst)
    |=> chan_a_lower_flag_r)
    else $error("A lower flag not held");
  low_wide_a: assert property (@(posedge clock) disable iff (rst) // RULE5
    conv.valid && conv.chan_a == {low_thr_r, 4'h0} |-> !hit_a.lower)
    else $error("Low threshold fill wrong");
  low_hit_a: assert property (@(posedge clock) disable iff (rst) // RULE6
    conv.chan_b > {low_thr_r, 4'h0} |-> !hit_b.lower)
    else $error("Low hit above threshold");
  high_wide_a: assert property (@(posedge clock) disable iff (rst) // RULE7
    conv.chan_a == {high_thr_r, 4'hf} |-> !hit_a.upper)
    else $error("High threshold fill wrong");
  high_hit_a: assert property (@(posedge clock) disable iff (rst) // RULE8
    conv.chan_b < {high_thr_r, 4'hf} |-> !hit_b.upper)
    else $error("High hit below threshold");
  low_reset_a: assert property (@(posedge clock) // RULE9
    $fell(rst) |-> low_thr_r == 12'h800 && low_addr_r == 4'h0)
    else $error("Low threshold reset wrong");
  high_reset_a: assert property (@(posedge clock) // RULE10
    $fell(rst) |-> high_thr_r == 12'h7ff && high_addr_r == 4'h0)
    else $error("High threshold reset wrong");
  hard_state_a: assert property (@(posedge clock) disable iff (rst) // RULE9
    rst_state_r == ST_HARD |-> low_thr_r == 12'h800 &&
    high_thr_r == 12'h7ff && flags == 6'h00)
    else $error("Hard reset defaults wrong");
  addr_echo_a: assert property (@(posedge clock) disable iff (rst) // RULE11
    wr_high ##1 (!wr_high && !hard_rst) ##1
    (req.rd && req.addr == `REG_HIGH_THR)
    |=> rdata[15:12] == $past(req.wdata[15:12], 3))
    else $error("Address not echoed");
  soft_clear_a: assert property (@(posedge clock) disable iff (rst) // RULE12
    soft_rst |=> flags == 6'h00 && $stable(low_thr_r))
    else $error("Soft reset wrong");
  soft_state_a: assert property (@(posedge clock) disable iff (rst) // RULE12
    rst_state_r == ST_SOFT |-> flags == 6'h00)
    else $error("Soft reset state flags set");
  status_read_a: assert property (@(posedge clock) disable iff (rst) // RULE13
    req.rd && req.addr == `REG_STATUS
    |=> rdata[15:12] == 4'h0 && rdata[3:2] == 2'h0)
    else $error("Status reserved bits set");
  reserved_zero_a: assert property (@(posedge clock) // RULE14
    disable iff (rst)
    status_word[11:6] == 6'h00 && status_word[3:2] == 2'h0)
    else $error("Reserved bits nonzero");
endmodule // limit_alert
`default_nettype wire

// *** conv_source.sv ***
// Purpose: Converter side model issuing end-of-conversion result pairs
// Assumes: One result pair per start request
// Notes: Outside the valid cycle the data lines toggle each cycle between the inverted and the true last word
`timescale 1ns/1ps
`default_nettype none
module conv_source
  import limit_alert_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bench request
  input wire logic start,
  input wire logic [15:0] a_in,
  input wire logic [15:0] b_in,
  // Result to block
  output var conv_result_t conv
);
  always_ff @(posedge clock) begin
    if (rst) begin
      conv <= '0;
    end else begin
      conv.valid <= start;
      if (start) begin
        conv.chan_a <= a_in;
        conv.chan_b <= b_in;
      end else begin
        conv.chan_a <= ~conv.chan_a;
        conv.chan_b <= ~conv.chan_b;
      end
    end
  end
endmodule // conv_source
`default_nettype wire

// *** limit_alert_test.sv ***
// Purpose: Self-checking bench for the limit alert block
// Assumes: Bench model tracks thresholds, flags and interrupt state
// Notes: Random thresholds and results from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
`include "limit_alert_defines.svh"
module limit_alert_test
  import limit_alert_pkg::*;
;
  logic clock, rst, start, irq;
  logic [15:0] a_in, b_in, rdata;
  logic [5:0] flags;
  logic [31:0] seed;
  reg_req_t req;
  conv_result_t conv;
  int err_total, check_count, cyc, lo, hi, fl, ist, ien;

  limit_alert limit_alert_inst (.clock(clock), .rst(rst), .req(req),
    .rdata(rdata), .conv(conv), .flags(flags), .irq(irq));
  conv_source conv_source_inst (.clock(clock), .rst(rst), .start(start),
    .a_in(a_in), .b_in(b_in), .conv(conv));

  // ****************************************
  // Tasks and model
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int hits(input int a, input int b);
    int l, h, r;
    l = lo * 16;
    h = hi * 16 + 15;
    r = 0;
    if (a < l) r |= 1;
    if (a > h) r |= 2;
    if (b < l) r |= 16;
    if (b > h) r |= 32;
    return r;
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [11:0] d);
    @(posedge clock);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= {a, d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clock);
    req.rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask

  task automatic do_conv(input logic [15:0] a, input logic [15:0] b);
    int h;
    @(posedge clock);
    start <= 1'b1;
    a_in <= a;
    b_in <= b;
    @(posedge clock);
    start <= 1'b0;
    @(posedge clock);
    #1;
    h = hits(a, b);
    fl |= h;
    ist |= h;
    chk("flags", 16'(flags), 16'(fl));
  endtask

  task automatic rd_stat();
    rd_reg(`REG_STATUS, 16'(fl));
    fl = 0;
    chk("flags", 16'(flags), 16'h0000);
  endtask

  task automatic irq_chk();
    @(posedge clock);
    #1 chk("irq", 16'(irq), 16'(|(ist & ien)));
  endtask

  task automatic end_sim();
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    rst = 1'b1;
    req = '0;
    start = 1'b0;
    a_in = 16'h0000;
    b_in = 16'h0000;
    lo = 'h800;
    hi = 'h7ff;
    seed = 32'h32f3;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd_reg(`REG_LOW_THR, 16'h0800);
    rd_reg(`REG_HIGH_THR, 16'h07ff);
    rd_stat();
    rd_reg(4'h9, 16'h0000);
    do_conv(16'h7fff, 16'h8000);
    wr_reg(`REG_STATUS, 12'h033);
    rd_stat();
    rd_stat();
    wr_reg(`REG_IRQ_ENABLE, 12'h033);
    ien = 'h33;
    irq_chk();
    rd_reg(`REG_IRQ_ENABLE, 16'h7033);
    rd_reg(`REG_IRQ_CLEAR, 16'h6000 | 16'(ist));
    wr_reg(`REG_IRQ_CLEAR, 12'h001);
    ist &= ~1;
    irq_chk();
    wr_reg(`REG_IRQ_CLEAR, 12'h020);
    ist &= ~'h20;
    irq_chk();
    for (int i = 0; i < 30; i++) begin
      seed = lfsr(seed);
      lo = seed[11:0];
      hi = seed[23:12];
      wr_reg(`REG_LOW_THR, seed[11:0]);
      wr_reg(`REG_HIGH_THR, seed[23:12]);
      rd_reg(`REG_HIGH_THR, {4'h5, seed[23:12]});
      do_conv(seed[15:0], seed[31:16]);
      do_conv({seed[11:0], 4'h0} - 16'h1, {seed[23:12], 4'hf});
      do_conv({seed[11:0], 4'h0}, {seed[23:12], 4'hf} + 16'h1);
      irq_chk();
      if (i % 3 == 0) begin
        rd_stat();
      end
    end
    do_conv(16'h0000, 16'hffff);
    wr_reg(`REG_CONFIG2, 12'h03c);
    fl = 0;
    #1 chk("flags", 16'(flags), 16'h0000);
    rd_reg(`REG_LOW_THR, {4'h4, 12'(lo)});
    rd_reg(`REG_CONFIG2, 16'h203c);
    irq_chk();
    wr_reg(`REG_IRQ_ENABLE, 12'h000);
    ien = 0;
    irq_chk();
    wr_reg(`REG_CONFIG2, 12'h0ff);
    lo = 'h800;
    hi = 'h7ff;
    ist = 0;
    fl = 0;
    rd_reg(`REG_LOW_THR, 16'h0800);
    rd_reg(`REG_HIGH_THR, 16'h07ff);
    rd_reg(`REG_CONFIG2, 16'h0000);
    rd_stat();
    end_sim();
  end
endmodule // limit_alert_test
`default_nettype wire
